// >>> hdl/fws_status_bank.sv
// sticky fault and wake status registers behind the serial command port
`timescale 1ns/100ps
`include "fws_map.svh"
module fws_status_bank
  import fws_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       softReset,
  input  wire logic       csN,
  input  wire logic       sclkRise,
  input  wire logic       mosi,
  input  wire logic       secondLevelThermalShutdown,
  input  wire logic       firstLevelThermalShutdown,
  input  wire logic       thermalPrewarning,
  input  wire logic       restartFailure,
  input  wire logic       supplyOvervoltage,
  input  wire logic       supplyOvervoltageResetEnable,
  input  wire logic       sleepEntry,
  input  wire logic       sleepWithFlagsPending,
  input  wire logic [2:0] configSetting,
  input  wire logic       watchdogFail,
  input  wire logic       watchdogTriggerOk,
  input  wire logic       watchdogStopped,
  input  wire logic       stopDueToWatchdog,
  input  wire logic       transmitDominantTimeout,
  input  wire logic       busDominantTimeout,
  input  wire logic       busThermalShutdown,
  input  wire logic       transceiverModeOne,
  input  wire logic       transceiverSupplyUndervoltage,
  input  wire logic       busWake,
  input  wire logic       timerWake,
  input  wire logic [2:0] wakeInput,
  input  wire logic       failSafeWake,
  output logic            miso,
  output logic            failSafeRequest,
  output logic            restartRequest,
  output logic            failOutput,
  output logic            transmitterDisable
);
  fws_cmd_if cmd ();
  logic [2:0] thermalFlags;
  logic [1:0] previousStateField;
  logic [1:0] watchdogFailureCounter;
  logic       frozen;
  logic       commandError;
  logic       failureFlag;
  logic [1:0] busFault;
  logic       transceiverUvFlag;
  logic [4:0] wakeFlags;
  logic       invalidCmd;

  fws_serial_port u_port (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .csN      (csN),
    .sclkRise (sclkRise),
    .mosi     (mosi),
    .miso     (miso),
    .cmdError (invalidCmd),
    .cmd      (cmd)
  );

  // clear strobes per register, decoded from the taken command
  function automatic logic hit(input logic [6:0] a, input logic [6:0] ref_a);
    return cmd.valid && cmd.clearReq && (a == ref_a);
  endfunction
  wire clrTherm = hit(cmd.addr, `FWS_ADDR_THERM);
  wire clrDev   = hit(cmd.addr, `FWS_ADDR_DEV);
  wire clrBus   = hit(cmd.addr, `FWS_ADDR_BUS);
  wire clrWake  = hit(cmd.addr, `FWS_ADDR_WAKE);

  // read mux; reserved bits forced to zero by the masks, in the device register by constant zeros
  wire [7:0] thermRead = {5'h00, thermalFlags} & `FWS_THERM_MASK;
  wire [7:0] devRead   = {previousStateField, 2'h0, watchdogFailureCounter,
                          commandError, failureFlag};
  wire [7:0] busRead   = {5'h00, busFault, transceiverUvFlag} & `FWS_BUS_MASK;
  wire [7:0] wakeRead  = {2'h0, wakeFlags[4:3], 1'b0, wakeFlags[2:0]} & `FWS_WAKE_MASK;
  assign cmd.readData = (cmd.addr == `FWS_ADDR_THERM) ? thermRead :
                        (cmd.addr == `FWS_ADDR_DEV)   ? devRead :
                        (cmd.addr == `FWS_ADDR_BUS)   ? busRead :
                        (cmd.addr == `FWS_ADDR_WAKE)  ? wakeRead : `FWS_RESET_VALUE;

  // thermal events; the clear is applied first so a coincident set wins
  wire [2:0] thermSet = {secondLevelThermalShutdown, firstLevelThermalShutdown,
                         thermalPrewarning};
  wire [2:0] next_thermal = (clrTherm ? 3'h0 : thermalFlags) | thermSet;

  // restart cause selection; failure outranks the sleep report
  wire failCause = restartFailure || secondLevelThermalShutdown || watchdogFail ||
                   (supplyOvervoltage && supplyOvervoltageResetEnable);
  wire [1:0] next_prev = failCause ? `FWS_PREV_FAILURE :
                         (sleepEntry || sleepWithFlagsPending) ? `FWS_PREV_SLEEP :
                         clrDev ? `FWS_PREV_CLEARED : previousStateField;

  // watchdog counter: failure threshold depends on configuration
  wire       cfgFreeze   = (configSetting == FWS_CFG2) || (configSetting == FWS_CFG4);
  wire [1:0] failLimit   = (configSetting == FWS_CFG2) ? `FWS_WD_ONE : `FWS_WD_TWO;
  wire       wdStepOk    = watchdogFail && !frozen && (watchdogFailureCounter != `FWS_WD_TWO);
  wire [1:0] countStep   = watchdogFailureCounter + 2'h1;
  wire       countClear  = watchdogTriggerOk || (watchdogStopped && !stopDueToWatchdog);
  wire [1:0] next_count  = countClear ? `FWS_WD_NONE :
                           wdStepOk ? countStep : watchdogFailureCounter;
  // config 0 on a first failure only restarts: no fail output, no flag
  wire       failFire    = wdStepOk && (countStep == failLimit) &&
                           !((configSetting == FWS_CFG0) && (countStep == `FWS_WD_ONE));

  // bus fault: newest event chosen by priority, bus dominant highest
  wire [1:0] busEvent = busDominantTimeout      ? FWS_BUS_BUSDOM :
                        transmitDominantTimeout ? FWS_BUS_TXDOM :
                        busThermalShutdown      ? FWS_BUS_TSD : FWS_BUS_OK;
  wire       uvSeen   = transceiverSupplyUndervoltage && transceiverModeOne;

  // wake sources; fail-safe wake still records its source
  wire [4:0] wakeSet = {busWake, timerWake, wakeInput};

  // soft reset clears everything as power-on does; restart mode keeps flags
  always_ff @(posedge ref_clk) begin
    if (rst || softReset) begin
      thermalFlags           <= 3'h0;
      previousStateField     <= `FWS_PREV_CLEARED;
      watchdogFailureCounter <= `FWS_WD_NONE;
      frozen                 <= 1'b0;
      commandError           <= 1'b0;
      failureFlag            <= 1'b0;
      busFault               <= FWS_BUS_OK;
      transceiverUvFlag      <= 1'b0;
      wakeFlags              <= 5'h00;
      failSafeRequest        <= 1'b0;
      restartRequest         <= 1'b0;
      failOutput             <= 1'b0;
      transmitterDisable     <= 1'b0;
    end else begin
      thermalFlags           <= next_thermal;
      previousStateField     <= next_prev;
      watchdogFailureCounter <= next_count;
      // freeze from the fail-output step until a good trigger; config 4 still reaches two
      frozen <= watchdogTriggerOk ? 1'b0 : (frozen || (failFire && cfgFreeze));
      commandError       <= (commandError && !clrDev) || invalidCmd;
      failureFlag        <= (failureFlag && !clrDev) || failFire;
      failOutput         <= failFire;
      busFault           <= (busEvent != FWS_BUS_OK) ? busEvent :
                            (clrBus ? FWS_BUS_OK : busFault);
      transceiverUvFlag  <= (transceiverUvFlag && !clrBus) || uvSeen;
      transmitterDisable <= uvSeen;
      wakeFlags          <= (clrWake ? 5'h00 : wakeFlags) | wakeSet;
      failSafeRequest    <= secondLevelThermalShutdown;
      restartRequest     <= watchdogFail;
    end
  end

  a_second_level_thermal_shutdown_failsafe: assert property (@(posedge ref_clk) disable iff (rst || softReset)
    !softReset && secondLevelThermalShutdown |=> failSafeRequest && thermalFlags[2])
    else $error("second_level_thermal_shutdown did not force fail-safe");
  a_thermal_sticky: assert property (@(posedge ref_clk) disable iff (rst || softReset)
    !softReset && thermalFlags[1] && !clrTherm |=> thermalFlags[1])
    else $error("thermal flag dropped");
  a_set_beats_clear: assert property (@(posedge ref_clk) disable iff (rst || softReset)
    !softReset && clrWake |=> wakeFlags == $past(wakeSet))
    else $error("wake lost to clear");
  // a fail-safe wake keeps every source flag that came with it
  a_failsafe_wake: assert property (@(posedge ref_clk) disable iff (rst || softReset)
    !softReset && failSafeWake && (wakeSet != 5'h00) |=>
      (wakeFlags & $past(wakeSet)) == $past(wakeSet))
    else $error("fail-safe wake source lost");
  a_cause_failure: assert property (@(posedge ref_clk) disable iff (rst || softReset)
    !softReset && watchdogFail |=> previousStateField == 2'h1)
    else $error("failure code missing");
  a_counter_bound: assert property (@(posedge ref_clk) disable iff (rst || softReset)
    watchdogFailureCounter != 2'h3)
    else $error("counter reached 11");
  a_trigger_clears: assert property (@(posedge ref_clk) disable iff (rst || softReset)
    watchdogTriggerOk |=> watchdogFailureCounter == 2'h0 && !frozen)
    else $error("trigger did not clear");
  a_uv_gated: assert property (@(posedge ref_clk) disable iff (rst || softReset)
    !transceiverModeOne && !transceiverUvFlag |=> !transceiverUvFlag)
    else $error("uv set outside mode one");
  a_cfg0_quiet: assert property (@(posedge ref_clk) disable iff (rst || softReset)
    configSetting == 3'h0 && watchdogFailureCounter == 2'h0 |=> !failOutput)
    else $error("cfg0 first failure fired");
  a_error_flag: assert property (@(posedge ref_clk) disable iff (rst || softReset)
    !softReset && invalidCmd |=> commandError ##1 commandError)
    else $error("command error not kept");
endmodule // fws_status_bank

// >>> hdl/fws_map.svh
// register map and field constants for the fault and wake status bank
// How it works
// - second-level shutdown sets bit 2, forces fail-safe
// - first-level shutdown sets thermal bit 1
// - thermal prewarning sets thermal bit 0
// - thermal flags sticky until host clear
// - thermal zero at reset, flags kept through restart
// - previous-state field at bits 7:6 encodes origin
// - failure restart causes record code 01
// - sleep attempt with wake flags pending records 10
// - watchdog failure field counts failures, bits 3:2
// - counter self-clears on trigger or a watchdog stop not due to watchdog
// - configs 2 and 4 freeze counter until trigger
// - config 0 first failure: restart only
// - invalid command sets error bit 1, host-cleared
// - fail output activation sets failure bit 0
// - bus fault field bits 2:1 encodes fault
// - transceiver undervoltage sets bit 0, disables transmitter
// - undervoltage comparator active only in mode one
// - wake register flags bus, timer, three inputs
// - wake from fail-safe also sets source flag
// - wake flags zero at reset, kept through restart
// - one 16-bit command: address, mode, data
// - command bit 7 set reads then clears
`ifndef FWS_MAP_SVH
`define FWS_MAP_SVH
`define FWS_ADDR_THERM   7'h42
`define FWS_ADDR_DEV     7'h43
`define FWS_ADDR_BUS     7'h44
`define FWS_ADDR_WAKE    7'h46
`define FWS_THERM_MASK   8'h07
`define FWS_DEV_MASK     8'hC3
`define FWS_BUS_MASK     8'h07
`define FWS_WAKE_MASK    8'h37
`define FWS_RESET_VALUE  8'h00
`define FWS_PREV_CLEARED 2'h0
`define FWS_PREV_FAILURE 2'h1
`define FWS_PREV_SLEEP   2'h2
`define FWS_WD_NONE      2'h0
`define FWS_WD_ONE       2'h1
`define FWS_WD_TWO       2'h2
`define FWS_CMD_BITS     16
`endif

// >>> hdl/fws_pkg.sv
// types for the fault and wake status bank
package fws_pkg;
  typedef enum logic [2:0] {
    FWS_CFG0 = 3'h0,
    FWS_CFG1 = 3'h1,
    FWS_CFG2 = 3'h2,
    FWS_CFG3 = 3'h3,
    FWS_CFG4 = 3'h4
  } fws_cfg_t;
  typedef enum logic [1:0] {
    FWS_BUS_OK     = 2'h0,
    FWS_BUS_TSD    = 2'h1,
    FWS_BUS_TXDOM  = 2'h2,
    FWS_BUS_BUSDOM = 2'h3
  } fws_bus_fault_t;
  typedef enum logic [1:0] {
    FWS_IDLE = 2'h0,
    FWS_BUSY = 2'h1,
    FWS_DONE = 2'h2
  } fws_shift_t;
endpackage

// >>> hdl/fws_cmd_if.sv
// carrier between the serial front end and the register bank
`timescale 1ns/100ps
interface fws_cmd_if;
  logic       valid;
  logic [6:0] addr;
  logic       clearReq;
  logic [7:0] readData;
  modport front (output valid, output addr, output clearReq, input readData);
  modport bank  (input valid, input addr, input clearReq, output readData);
endinterface

// >>> hdl/fws_serial_port.sv
// 16-bit serial command shifter and reply path
`timescale 1ns/100ps
`include "fws_map.svh"
module fws_serial_port
  import fws_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic csN,
  input  wire logic sclkRise,
  input  wire logic mosi,
  output logic      miso,
  output logic      cmdError,
  fws_cmd_if.front  cmd
);
  logic [4:0]  bitCount;
  logic [15:0] shiftIn;
  logic [7:0]  shiftOut;
  logic        csLast;
  fws_shift_t  state;
  wire  frameEnd = csN && !csLast;
  wire  frameOk  = (bitCount == 5'(`FWS_CMD_BITS));

  // shift while selected; frame is judged on deselect, first bit is bit 0
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bitCount <= 5'h00;
      shiftIn  <= 16'h0000;
      shiftOut <= 8'h00;
      csLast   <= 1'b1;
      state    <= FWS_IDLE;
      miso     <= 1'b0;
      cmdError <= 1'b0;
      cmd.valid    <= 1'b0;
      cmd.addr     <= 7'h00;
      cmd.clearReq <= 1'b0;
    end else begin
      csLast    <= csN;
      cmd.valid <= 1'b0;
      cmdError  <= 1'b0;
      case (state)
        FWS_IDLE: begin
          bitCount <= 5'h00;
          if (!csN) state <= FWS_BUSY;
        end
        FWS_BUSY: begin
          if (sclkRise && !csN) begin
            shiftIn  <= {mosi, shiftIn[15:1]};
            bitCount <= (bitCount == 5'h1F) ? bitCount : bitCount + 5'h01;
            // address goes out at the seventh bit, so the reply is this frame's register
            if (bitCount == 5'h06) cmd.addr <= {mosi, shiftIn[15:10]};
            // after the address byte, reply with the addressed register
            if (bitCount == 5'h07) shiftOut <= cmd.readData;
            else if (bitCount > 5'h07) begin
              miso     <= shiftOut[0];
              shiftOut <= {1'b0, shiftOut[7:1]};
            end
          end
          if (frameEnd) state <= FWS_DONE;
        end
        FWS_DONE: begin
          // wrong length frames are invalid commands
          cmd.valid    <= frameOk;
          cmd.addr     <= shiftIn[6:0];
          cmd.clearReq <= shiftIn[7];
          cmdError     <= !frameOk;
          state        <= FWS_IDLE;
        end
        default: state <= FWS_IDLE;
      endcase
    end
  end
  // a clean frame is 16 clocks
  a_frame_length: assert property (@(posedge ref_clk) disable iff (rst)
    cmd.valid |-> $past(bitCount, 2) == 5'd16) else $error("bad frame length");
endmodule // fws_serial_port

// >>> sim/fws_host_model.sv
// host side model that shifts 16-bit commands into the status bank
`timescale 1ns/100ps
module fws_host_model (
  input  wire logic ref_clk,
  input  wire logic miso,
  output logic      csN,
  output logic      sclkRise,
  output logic      mosi
);
  // idle bus: deselected, no clock pulse
  initial begin
    csN = 1'b1;
    sclkRise = 1'b0;
    mosi = 1'b0;
  end

  // one frame, lsb first, address then mode bit then data byte
  // a pulse count other than 16 is how the bench makes a refused frame
  task automatic frame(input logic [15:0] word, input int pulses, output logic [7:0] reply);
    reply = 8'h00;
    @(posedge ref_clk);
    csN <= 1'b0;
    for (int i = 0; i < pulses; i++) begin
      @(posedge ref_clk);
      mosi <= word[i];
      @(posedge ref_clk);
      sclkRise <= 1'b1;
      @(posedge ref_clk);
      sclkRise <= 1'b0;
      repeat (2) @(posedge ref_clk);
      // reply bit is settled well after its pulse
      if (i >= 8) begin
        reply[i - 8] = miso;
      end
    end
    @(posedge ref_clk);
    csN <= 1'b1;
    mosi <= ~mosi;  // released line never keeps its last value
    // gap covers the take and the clear before the next frame
    repeat (5) @(posedge ref_clk);
  endtask
endmodule // fws_host_model

// >>> sim/tb_fws_status_bank.sv
// self-checking bench for the fault and wake status bank
`timescale 1ns/100ps
`include "fws_map.svh"
module tb_fws_status_bank;
  logic        ref_clk;
  logic        rst;
  logic [23:0] ev;
  logic [2:0]  cfg;
  logic        csN;
  logic        sclkRise;
  logic        mosi;
  logic        miso;
  logic        failSafeRequest;
  logic        restartRequest;
  logic        failOutput;
  logic        transmitterDisable;
  logic [7:0]  rd;
  int          failures = 0;
  int          samples_checked = 0;
  int          fsCount = 0;
  int          foCount = 0;
  int          rrCount = 0;
  int          busBit[3] = '{12, 10, 11};

  fws_status_bank i_fws_status_bank (
    .ref_clk(ref_clk), .rst(rst), .softReset(ev[18]), .csN(csN), .sclkRise(sclkRise),
    .mosi(mosi), .secondLevelThermalShutdown(ev[0]), .firstLevelThermalShutdown(ev[1]),
    .thermalPrewarning(ev[2]), .restartFailure(ev[3]), .supplyOvervoltage(ev[4]),
    .supplyOvervoltageResetEnable(ev[5]), .sleepEntry(ev[6]),
    .sleepWithFlagsPending(ev[7]), .configSetting(cfg), .watchdogFail(ev[8]),
    .watchdogTriggerOk(ev[9]), .watchdogStopped(ev[22]), .stopDueToWatchdog(ev[23]),
    .transmitDominantTimeout(ev[10]), .busDominantTimeout(ev[11]),
    .busThermalShutdown(ev[12]), .transceiverModeOne(ev[13]),
    .transceiverSupplyUndervoltage(ev[14]), .busWake(ev[15]), .timerWake(ev[16]),
    .wakeInput(ev[21:19]), .failSafeWake(ev[17]), .miso(miso),
    .failSafeRequest(failSafeRequest), .restartRequest(restartRequest),
    .failOutput(failOutput), .transmitterDisable(transmitterDisable)
  );

  fws_host_model i_fws_host_model (
    .ref_clk(ref_clk), .miso(miso), .csN(csN), .sclkRise(sclkRise), .mosi(mosi)
  );

  // clock and reset; all event inputs quiet at time zero
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    rst = 1'b1;
    ev = 24'h000000;
    cfg = 3'h1;
  end

  // count output pulses so short ones are not missed between frames
  always @(posedge ref_clk) begin
    if (failSafeRequest === 1'b1) fsCount <= fsCount + 1;
    if (failOutput === 1'b1) foCount <= foCount + 1;
    if (restartRequest === 1'b1) rrCount <= rrCount + 1;
  end

  task automatic drive(input int b, input logic v);
    @(posedge ref_clk);
    ev[b] <= v;
  endtask
  task automatic pulse(input int b);
    drive(b, 1'b1);
    drive(b, 1'b0);
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // read (c=0) or read-and-clear (c=1) one register, compare masked reply
  task automatic chk(input logic [6:0] a, input logic c, input logic [7:0] e,
                     input logic [7:0] m);
    logic [7:0] r;
    i_fws_host_model.frame({8'h00, c, a}, 16, r);
    cmp(r & m, e);
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // a frame is under 100 cycles, the whole run well under this bound
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    report_and_stop;
  end

  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    chk(`FWS_ADDR_THERM, 1'b0, 8'h00, 8'hFF);
    chk(`FWS_ADDR_DEV, 1'b0, 8'h00, 8'hFF);
    chk(`FWS_ADDR_WAKE, 1'b0, 8'h00, 8'hFF);
    chk(7'h45, 1'b0, 8'h00, 8'hFF);
    pulse(0);
    pulse(1);
    pulse(2);
    cmp(8'(fsCount > 0), 8'h01);
    chk(`FWS_ADDR_THERM, 1'b1, 8'h07, 8'hFF);
    chk(`FWS_ADDR_THERM, 1'b0, 8'h00, 8'hFF);
    chk(`FWS_ADDR_DEV, 1'b1, 8'h40, 8'hC0);
    // gated undervoltage, then the three fault codes
    drive(14, 1'b1);
    chk(`FWS_ADDR_BUS, 1'b1, 8'h00, 8'hFF);
    cmp({7'h00, transmitterDisable}, 8'h00);
    drive(13, 1'b1);
    repeat (3) @(posedge ref_clk);
    cmp({7'h00, transmitterDisable}, 8'h01);
    drive(14, 1'b0);
    chk(`FWS_ADDR_BUS, 1'b1, 8'h01, 8'hFF);
    for (int k = 0; k < 3; k++) begin
      pulse(busBit[k]);
      chk(`FWS_ADDR_BUS, 1'b1, 8'(2 * (k + 1)), 8'hFF);
    end
    // every wake source while waking from fail-safe
    for (int b = 19; b < 22; b++) drive(b, 1'b1);
    drive(17, 1'b1);
    pulse(15);
    pulse(16);
    @(posedge ref_clk);
    ev <= 24'h000000;
    chk(`FWS_ADDR_WAKE, 1'b1, 8'h37, 8'hFF);
    chk(`FWS_ADDR_WAKE, 1'b0, 8'h00, 8'hFF);
    pulse(2);
    pulse(18);
    chk(`FWS_ADDR_THERM, 1'b0, 8'h00, 8'hFF);
    // two watchdog failures in configuration 1
    pulse(8);
    repeat (4) @(posedge ref_clk);
    pulse(8);
    chk(`FWS_ADDR_DEV, 1'b1, 8'h49, 8'hFF);
    cmp(8'(foCount), 8'h01);
    cmp(8'(rrCount), 8'h02);
    pulse(9);
    chk(`FWS_ADDR_DEV, 1'b0, 8'h00, 8'hFF);
    // configuration 0: restart only, no failure flag
    @(posedge ref_clk);
    cfg <= 3'h0;
    pulse(8);
    chk(`FWS_ADDR_DEV, 1'b1, 8'h40, 8'hC1);
    cmp(8'(foCount), 8'h01);
    // a stop caused by the watchdog keeps the count, any other stop clears it
    drive(23, 1'b1);
    pulse(22);
    chk(`FWS_ADDR_DEV, 1'b0, 8'h04, 8'h0C);
    drive(23, 1'b0);
    pulse(22);
    chk(`FWS_ADDR_DEV, 1'b0, 8'h00, 8'h0C);
    pulse(9);
    drive(5, 1'b1);
    for (int b = 3; b < 5; b++) begin
      pulse(b);
      chk(`FWS_ADDR_DEV, 1'b1, 8'h40, 8'hC0);
    end
    // configuration 2: one failure fires, then the count stays frozen
    @(posedge ref_clk);
    cfg <= 3'h2;
    pulse(8);
    repeat (4) @(posedge ref_clk);
    pulse(8);
    chk(`FWS_ADDR_DEV, 1'b1, 8'h45, 8'hCF);
    cmp(8'(foCount), 8'h02);
    pulse(9);
    chk(`FWS_ADDR_DEV, 1'b0, 8'h00, 8'hCF);
    pulse(6);
    chk(`FWS_ADDR_DEV, 1'b1, 8'h80, 8'hC0);
    pulse(7);
    chk(`FWS_ADDR_DEV, 1'b1, 8'h80, 8'hC0);
    i_fws_host_model.frame(16'h0043, 15, rd);
    chk(`FWS_ADDR_DEV, 1'b1, 8'h02, 8'h32);
    chk(`FWS_ADDR_DEV, 1'b0, 8'h00, 8'hF3);
    report_and_stop;
  end
endmodule // tb_fws_status_bank
